//--- core/ddp_pkg.sv
// Shared constants and types for the DDR3-style data pin link.
// Contract
// - Device reset is asynchronous, active when low
// - Controller keeps reset high during normal operation
// - Leveling feedback rides DQ0, and DQ8 on x16
// - Device drives strobe on reads, controller on writes
// - Read strobe edge-aligned, write strobe centred on data
// - Strobe always a true and complement pair
// - Bit 11 set: termination strobe gets strobe termination
// - Bit 11 clear: shared pin is write mask
// - x16 controller always programs bit 11 to zero
// - Masked write beats discarded, mask sampled per beat
// - Bank address selects mode register on set
package ddp_pkg;

  // ************************************************************
  // Link geometry and latencies
  // ************************************************************
  localparam int DQ_W_DEF = 8;
  localparam int BYTE_W = 8;
  localparam int AW_DEF = 4;
  localparam int BURST_DEF = 4;
  localparam int WL_DEF = 2;
  localparam int RL_DEF = 3;
  // Strobe pulse late enough that its three-flop return on the prime bit is still standing at the sample fall
  localparam int LEV_HI_C = 3;
  localparam int LEV_SAMPLE_C = 6;
  localparam int NUM_MR = 4;
  localparam int MR_W = 16;
  localparam int MR_IDX_W = 2;

  // ************************************************************
  // Mode register fields
  // ************************************************************
  localparam int MR1_IDX = 1;
  localparam int MR1_TDQS_BIT = 11;
  localparam int MR1_WLEV_BIT = 7;
  localparam logic [MR_W-1:0] MR_RESET = 16'h0000;

  // ************************************************************
  // Link clock divider: four system cycles per link cycle
  // ************************************************************
  localparam logic [1:0] PH_FALL = 2'h1;
  localparam logic [1:0] PH_RISE = 2'h3;
  localparam logic [1:0] PH_HIGH0 = 2'h0;

  typedef enum logic [1:0] {CMD_NOP, CMD_MRS, CMD_WR, CMD_RD} ddp_cmd_t;
  typedef enum logic [1:0] {REQ_MRS, REQ_WR, REQ_RD, REQ_WLEV} ddp_req_t;

endpackage : ddp_pkg

//--- core/ddp_if.sv
// Interface joining the memory device end and the controller end.
interface ddp_if #(
  parameter int DQ_W = ddp_pkg::DQ_W_DEF
);
  localparam int NL = DQ_W / ddp_pkg::BYTE_W;

  logic ck;
  logic reset_n;
  ddp_pkg::ddp_cmd_t cmd;
  logic [2:0] ba;
  logic [15:0] addr;
  logic [DQ_W-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [NL-1:0] ctl_dqs_t;
  logic [NL-1:0] ctl_dqs_c;
  logic ctl_dqs_oe;
  logic [NL-1:0] ctl_dm;
  logic ctl_dm_oe;
  logic [DQ_W-1:0] dev_dq_o;
  logic [DQ_W-1:0] dev_dq_oe;
  logic [NL-1:0] dev_dqs_t;
  logic [NL-1:0] dev_dqs_c;
  logic dev_dqs_oe;
  logic dqs_term;
  logic tdqs_term;
  logic [DQ_W-1:0] dq;
  logic [NL-1:0] dqs_t;
  logic [NL-1:0] dqs_c;
  logic [NL-1:0] dm;

  // Wire levels resolved from the enables; undriven bits read low
  assign dq = ({DQ_W{ctl_dq_oe}} & ctl_dq_o) | (dev_dq_oe & dev_dq_o);
  assign dqs_t = ({NL{ctl_dqs_oe}} & ctl_dqs_t) | ({NL{dev_dqs_oe}} & dev_dqs_t);
  assign dqs_c = ({NL{ctl_dqs_oe}} & ctl_dqs_c) | ({NL{dev_dqs_oe}} & dev_dqs_c);
  assign dm = {NL{ctl_dm_oe}} & ctl_dm;

  modport dev (
    input ck,
    input reset_n,
    input cmd,
    input ba,
    input addr,
    input dq,
    input dqs_t,
    input dqs_c,
    input dm,
    output dev_dq_o,
    output dev_dq_oe,
    output dev_dqs_t,
    output dev_dqs_c,
    output dev_dqs_oe,
    output dqs_term,
    output tdqs_term
  );

  modport ctl (
    output ck,
    output reset_n,
    output cmd,
    output ba,
    output addr,
    output ctl_dq_o,
    output ctl_dq_oe,
    output ctl_dqs_t,
    output ctl_dqs_c,
    output ctl_dqs_oe,
    output ctl_dm,
    output ctl_dm_oe,
    input dq,
    input dqs_t,
    input dqs_c
  );
endinterface : ddp_if

//--- core/ddp_dev.sv
// Memory device end: mode registers, burst write with mask, burst read, leveling feedback.
module ddp_dev #(
  parameter int DQ_W = ddp_pkg::DQ_W_DEF,
  parameter int AW = ddp_pkg::AW_DEF,
  parameter int BURST = ddp_pkg::BURST_DEF,
  parameter int WL = ddp_pkg::WL_DEF,
  parameter int RL = ddp_pkg::RL_DEF
) (
  ddp_if.dev LNK,
  output logic MODE_TDQS,
  output logic MODE_WLEV,
  output logic BUSY
);
  import ddp_pkg::*;

  localparam int NL = DQ_W / BYTE_W;

  typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RD} ddp_dst_t;

  ddp_dst_t state_reg;
  logic [7:0] cnt_reg;
  logic [AW-1:0] base_reg;
  logic [MR_W-1:0] mr_reg [NUM_MR];
  logic [DQ_W-1:0] mem [2**AW];
  logic [NL-1:0] dqs_s1_reg;
  logic [NL-1:0] dqs_s2_reg;
  logic [DQ_W-1:0] dq_o_reg;
  logic [DQ_W-1:0] dq_oe_reg;
  logic [NL-1:0] dqs_t_reg;
  logic dqs_oe_reg;
  logic tdqs_en;
  logic wlev_en;
  logic wbeat;
  logic rbeat;
  logic [AW-1:0] waddr;
  logic [AW-1:0] raddr;
  logic [DQ_W-1:0] prime_mask;
  logic [DQ_W-1:0] fb_word;

  // ************************************************************
  // Mode decode
  // ************************************************************
  assign tdqs_en = (DQ_W == BYTE_W) && mr_reg[MR1_IDX][MR1_TDQS_BIT];
  assign wlev_en = mr_reg[MR1_IDX][MR1_WLEV_BIT];
  assign MODE_TDQS = tdqs_en;
  assign MODE_WLEV = wlev_en;
  assign BUSY = (state_reg != ST_IDLE);

  // ************************************************************
  // Burst sequencing
  // ************************************************************
  always_ff @(posedge LNK.ck or negedge LNK.reset_n) begin
    if (!LNK.reset_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      base_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (LNK.cmd == CMD_WR || LNK.cmd == CMD_RD) begin
            state_reg <= (LNK.cmd == CMD_WR) ? ST_WR : ST_RD;
            cnt_reg <= 8'h01;
            base_reg <= LNK.addr[AW-1:0];
          end
        end
        ST_WR: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == 8'(WL + BURST - 1)) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_RD: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == 8'(RL + BURST)) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Mode registers
  // ************************************************************
  // Commands arriving mid-burst are ignored, mode sets included
  always_ff @(posedge LNK.ck or negedge LNK.reset_n) begin
    if (!LNK.reset_n) begin
      for (int i = 0; i < NUM_MR; i++) begin
        mr_reg[i] <= MR_RESET;
      end
    end else if (state_reg == ST_IDLE && LNK.cmd == CMD_MRS) begin
      mr_reg[LNK.ba[MR_IDX_W-1:0]] <= LNK.addr;
    end
  end

  // ************************************************************
  // Write path
  // ************************************************************
  assign wbeat = (state_reg == ST_WR) && (cnt_reg >= 8'(WL)) && (cnt_reg < 8'(WL + BURST));
  assign waddr = base_reg + AW'(cnt_reg - 8'(WL));
  assign rbeat = (state_reg == ST_RD) && (cnt_reg >= 8'(RL)) && (cnt_reg < 8'(RL + BURST));
  assign raddr = base_reg + AW'(cnt_reg - 8'(RL));

  // Data is taken on the link clock; the write strobe toggles mid-eye, one edge per beat
  always_ff @(posedge LNK.ck) begin
    if (wbeat) begin
      for (int l = 0; l < NL; l++) begin
        if (tdqs_en || !LNK.dm[l]) begin
          mem[waddr][l*BYTE_W +: BYTE_W] <= LNK.dq[l*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // ************************************************************
  // Leveling feedback, one prime bit per byte lane
  // ************************************************************
  always_ff @(posedge LNK.ck or negedge LNK.reset_n) begin
    if (!LNK.reset_n) begin
      dqs_s1_reg <= '0;
      dqs_s2_reg <= '0;
    end else begin
      dqs_s1_reg <= LNK.dqs_t;
      dqs_s2_reg <= dqs_s1_reg;
    end
  end

  for (genvar l = 0; l < NL; l++) begin : g_lane
    assign prime_mask[l*BYTE_W +: BYTE_W] = 8'h01;
    assign fb_word[l*BYTE_W +: BYTE_W] = {7'h00, dqs_s2_reg[l]};
  end

  // ************************************************************
  // Read drive
  // ************************************************************
  always_ff @(posedge LNK.ck or negedge LNK.reset_n) begin
    if (!LNK.reset_n) begin
      dq_o_reg <= '0;
      dq_oe_reg <= '0;
      dqs_t_reg <= '0;
      dqs_oe_reg <= 1'b0;
    end else if (rbeat) begin
      dq_o_reg <= mem[raddr];
      dq_oe_reg <= '1;
      dqs_t_reg <= ~dqs_t_reg;
      dqs_oe_reg <= 1'b1;
    end else if (state_reg == ST_RD && cnt_reg == 8'(RL - 1)) begin
      // Preamble: strobe driven low one cycle before the first beat
      dq_oe_reg <= '0;
      dqs_t_reg <= '0;
      dqs_oe_reg <= 1'b1;
    end else if (wlev_en && state_reg == ST_IDLE) begin
      dq_o_reg <= fb_word;
      dq_oe_reg <= prime_mask;
      dqs_t_reg <= '0;
      dqs_oe_reg <= 1'b0;
    end else begin
      dq_o_reg <= '0;
      dq_oe_reg <= '0;
      dqs_t_reg <= '0;
      dqs_oe_reg <= 1'b0;
    end
  end

  assign LNK.dev_dq_o = dq_o_reg;
  assign LNK.dev_dq_oe = dq_oe_reg;
  assign LNK.dev_dqs_t = dqs_t_reg;
  assign LNK.dev_dqs_c = ~dqs_t_reg;
  assign LNK.dev_dqs_oe = dqs_oe_reg;

  // ************************************************************
  // Termination
  // ************************************************************
  assign LNK.dqs_term = (state_reg == ST_WR);
  assign LNK.tdqs_term = (state_reg == ST_WR) && tdqs_en;

endmodule : ddp_dev

//--- core/ddp_ctl.sv
// Controller end: link clock divider, memory reset, command issue, write drive, read capture, leveling.
module ddp_ctl #(
  parameter int DQ_W = ddp_pkg::DQ_W_DEF,
  parameter int BURST = ddp_pkg::BURST_DEF,
  parameter int WL = ddp_pkg::WL_DEF,
  parameter int RL = ddp_pkg::RL_DEF
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic MEM_RESET,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire ddp_pkg::ddp_req_t REQ_OP,
  input wire logic [2:0] REQ_BA,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [BURST*DQ_W-1:0] WR_DATA,
  input wire logic [BURST*(DQ_W/ddp_pkg::BYTE_W)-1:0] WR_MASK,
  output logic RD_VALID,
  output logic [BURST*DQ_W-1:0] RD_DATA,
  output logic LEV_VALID,
  output logic [DQ_W/ddp_pkg::BYTE_W-1:0] LEV_FB,
  ddp_if.ctl LNK
);
  import ddp_pkg::*;

  localparam int NL = DQ_W / BYTE_W;

  typedef enum logic {CS_IDLE, CS_BUSY} ddp_cst_t;

  ddp_cst_t state_reg;
  ddp_req_t op_reg;
  logic [1:0] ph_reg;
  logic ck_reg;
  logic rst_n_reg;
  logic [7:0] cnt_reg;
  logic [7:0] last_next;
  logic [7:0] last_reg;
  ddp_cmd_t cmd_reg;
  logic [2:0] ba_reg;
  logic [15:0] addr_reg;
  logic [15:0] addr_next;
  logic tdqs_reg;
  logic [BURST*DQ_W-1:0] wdata_reg;
  logic [BURST*NL-1:0] wmask_reg;
  logic [DQ_W-1:0] dq_o_reg;
  logic [NL-1:0] dm_reg;
  logic wr_oe_reg;
  logic dqs_oe_reg;
  logic dqs_t_reg;
  logic fall_tick;
  logic rise_tick;
  logic take;
  logic wr_beat;
  logic rd_beat;
  logic [7:0] wk;
  logic [7:0] rk;

  // ************************************************************
  // Link clock and memory reset
  // ************************************************************
  // Derived clock: high for phases 0 and 1, so command, data and mask updates land half a cycle from a rise
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ph_reg <= 2'h0;
      ck_reg <= 1'b0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
      ck_reg <= (ph_reg == PH_RISE) || (ph_reg == PH_HIGH0);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    rst_n_reg <= !(SRST || MEM_RESET);
  end

  assign fall_tick = (ph_reg == PH_FALL);
  assign rise_tick = (ph_reg == PH_RISE);
  assign REQ_READY = (state_reg == CS_IDLE) && fall_tick && rst_n_reg && !SRST;
  assign take = REQ_VALID && REQ_READY;

  // ************************************************************
  // Request sequencing
  // ************************************************************
  always_comb begin
    addr_next = REQ_ADDR;
    last_next = 8'h01;
    if (REQ_OP == REQ_MRS && REQ_BA[MR_IDX_W-1:0] == MR_IDX_W'(MR1_IDX) && DQ_W != BYTE_W) begin
      addr_next[MR1_TDQS_BIT] = 1'b0;
    end
    unique case (REQ_OP)
      REQ_MRS: last_next = 8'h01;
      REQ_WR: last_next = 8'(WL + BURST);
      REQ_RD: last_next = 8'(RL + BURST + 1);
      REQ_WLEV: last_next = 8'(LEV_SAMPLE_C);
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_reg <= CS_IDLE;
      op_reg <= REQ_MRS;
      cnt_reg <= 8'h00;
      last_reg <= 8'h00;
      cmd_reg <= CMD_NOP;
      ba_reg <= 3'h0;
      addr_reg <= 16'h0000;
      wdata_reg <= '0;
      wmask_reg <= '0;
    end else if (take) begin
      state_reg <= CS_BUSY;
      op_reg <= REQ_OP;
      cnt_reg <= 8'h01;
      last_reg <= last_next;
      ba_reg <= REQ_BA;
      addr_reg <= addr_next;
      wdata_reg <= WR_DATA;
      wmask_reg <= WR_MASK;
      unique case (REQ_OP)
        REQ_MRS: cmd_reg <= CMD_MRS;
        REQ_WR: cmd_reg <= CMD_WR;
        REQ_RD: cmd_reg <= CMD_RD;
        REQ_WLEV: cmd_reg <= CMD_NOP;
      endcase
    end else if (fall_tick && state_reg == CS_BUSY) begin
      cmd_reg <= CMD_NOP;
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg == last_reg) begin
        state_reg <= CS_IDLE;
      end
    end
  end

  // Mirror of the mode the device was put in; decides who owns the shared mask pin
  always_ff @(posedge SYS_CLK) begin
    if (SRST || !rst_n_reg) begin
      tdqs_reg <= 1'b0;
    end else if (take && REQ_OP == REQ_MRS && REQ_BA[MR_IDX_W-1:0] == MR_IDX_W'(MR1_IDX)) begin
      tdqs_reg <= addr_next[MR1_TDQS_BIT];
    end
  end

  // ************************************************************
  // Write drive
  // ************************************************************
  assign wk = cnt_reg - 8'(WL);
  assign rk = cnt_reg - 8'(RL + 1);
  assign wr_beat = (state_reg == CS_BUSY) && (op_reg == REQ_WR) && (cnt_reg >= 8'(WL))
                   && (cnt_reg < 8'(WL + BURST));
  assign rd_beat = (state_reg == CS_BUSY) && (op_reg == REQ_RD) && (cnt_reg > 8'(RL))
                   && (cnt_reg <= 8'(RL + BURST));

  // Data changes at the link fall, the strobe toggles at the rise
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      dq_o_reg <= '0;
      dm_reg <= '0;
      wr_oe_reg <= 1'b0;
      dqs_oe_reg <= 1'b0;
    end else if (fall_tick) begin
      wr_oe_reg <= wr_beat;
      dqs_oe_reg <= wr_beat || (state_reg == CS_BUSY && op_reg == REQ_WLEV && cnt_reg != last_reg);
      if (wr_beat) begin
        dq_o_reg <= wdata_reg[wk*DQ_W +: DQ_W];
        dm_reg <= wmask_reg[wk*NL +: NL];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      dqs_t_reg <= 1'b0;
    end else if (rise_tick && wr_oe_reg) begin
      dqs_t_reg <= ~dqs_t_reg;
    end else if (fall_tick && state_reg == CS_BUSY && op_reg == REQ_WLEV) begin
      dqs_t_reg <= (cnt_reg == 8'(LEV_HI_C));
    end else if (!dqs_oe_reg) begin
      dqs_t_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Read capture and leveling result
  // ************************************************************
  // Read data moves with the device strobe at the rise; sampling at the fall lands mid-eye
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      RD_DATA <= '0;
      RD_VALID <= 1'b0;
      LEV_FB <= '0;
      LEV_VALID <= 1'b0;
    end else begin
      RD_VALID <= fall_tick && state_reg == CS_BUSY && op_reg == REQ_RD && cnt_reg == last_reg;
      LEV_VALID <= fall_tick && state_reg == CS_BUSY && op_reg == REQ_WLEV && cnt_reg == last_reg;
      if (fall_tick && rd_beat) begin
        RD_DATA[rk*DQ_W +: DQ_W] <= LNK.dq;
      end
      if (fall_tick && state_reg == CS_BUSY && op_reg == REQ_WLEV && cnt_reg == last_reg) begin
        for (int l = 0; l < NL; l++) begin
          LEV_FB[l] <= LNK.dq[l*BYTE_W];
        end
      end
    end
  end

  assign LNK.ck = ck_reg;
  assign LNK.reset_n = rst_n_reg;
  assign LNK.cmd = cmd_reg;
  assign LNK.ba = ba_reg;
  assign LNK.addr = addr_reg;
  assign LNK.ctl_dq_o = dq_o_reg;
  assign LNK.ctl_dq_oe = wr_oe_reg;
  assign LNK.ctl_dqs_t = {NL{dqs_t_reg}};
  assign LNK.ctl_dqs_c = {NL{~dqs_t_reg}};
  assign LNK.ctl_dqs_oe = dqs_oe_reg;
  assign LNK.ctl_dm = dm_reg;
  assign LNK.ctl_dm_oe = wr_oe_reg && !tdqs_reg;

endmodule : ddp_ctl

//--- tb/ddp_link_properties.sv
// Checker of pin-level rules on the link between the controller and device ends.
module ddp_link_properties #(
  parameter int DQ_W = ddp_pkg::DQ_W_DEF,
  parameter int WL = ddp_pkg::WL_DEF,
  parameter int RL = ddp_pkg::RL_DEF
) (
  input wire logic ck,
  input wire logic reset_n,
  input wire ddp_pkg::ddp_cmd_t cmd,
  input wire logic [DQ_W-1:0] dq,
  input wire logic [DQ_W/ddp_pkg::BYTE_W-1:0] dqs_t,
  input wire logic [DQ_W/ddp_pkg::BYTE_W-1:0] dqs_c,
  input wire logic ctl_dq_oe,
  input wire logic ctl_dqs_oe,
  input wire logic ctl_dm_oe,
  input wire logic [DQ_W-1:0] dev_dq_oe,
  input wire logic dev_dqs_oe,
  input wire logic dqs_term,
  input wire logic tdqs_term
);
  import ddp_pkg::*;
  // Leveling feedback may only use the first bit of each byte lane
  localparam logic [DQ_W-1:0] LEV_MASK = DQ_W'(16'h0101);

  // ********
  // Strobe ownership and shape
  // ********
  a_strobe_diff_pair: assert property (
    @(posedge ck) disable iff (!reset_n) (ctl_dqs_oe || dev_dqs_oe) |-> (dqs_c == ~dqs_t))
    else $error("strobe pair not complementary");
  a_single_owner: assert property (
    @(posedge ck) disable iff (!reset_n) !(ctl_dqs_oe && dev_dqs_oe) && !(ctl_dq_oe && (dev_dq_oe != '0)))
    else $error("both ends drive the data pins");
  a_read_strobe_owner: assert property (
    @(posedge ck) disable iff (!reset_n) (cmd == CMD_RD) |-> ##RL dev_dqs_oe [*5] ##1 !dev_dqs_oe)
    else $error("device strobe drive window wrong on read");
  a_write_strobe_owner: assert property (
    @(posedge ck) disable iff (!reset_n) (cmd == CMD_WR) |-> ##WL ctl_dqs_oe [*4] ##1 !ctl_dqs_oe)
    else $error("controller strobe drive window wrong on write");
  // Any-edge clock: write data may move only half a cycle away from strobe edges
  a_write_eye_centre: assert property (
    @(ck) disable iff (!reset_n) (ctl_dq_oe && $past(ctl_dq_oe, 2) && $changed(dq)) |-> $stable(dqs_t))
    else $error("write data moved with a strobe edge");
  a_read_edge_aligned: assert property (
    @(ck) disable iff (!reset_n) (dev_dqs_oe && $past(dev_dqs_oe, 2) && $changed(dq)) |-> $changed(dqs_t))
    else $error("read data moved without a strobe edge");

  // ********
  // Leveling, termination, mask and reset
  // ********
  a_lev_prime_bit: assert property (
    @(posedge ck) disable iff (!reset_n) !dev_dqs_oe |-> ((dev_dq_oe & ~LEV_MASK) == '0))
    else $error("feedback driven on a non-prime bit");
  a_tdqs_follows_dqs: assert property (
    @(posedge ck) disable iff (!reset_n) tdqs_term |-> dqs_term)
    else $error("termination strobe terminated alone");
  a_mask_pin_idle: assert property (
    @(posedge ck) disable iff (!reset_n) tdqs_term |-> !ctl_dm_oe)
    else $error("mask driven while pin is a termination strobe");
  a_mask_with_data: assert property (
    @(posedge ck) disable iff (!reset_n) ctl_dm_oe |-> ctl_dq_oe)
    else $error("mask driven outside write data");
  a_reset_quiet: assert property (
    @(posedge ck) !reset_n |-> (dev_dq_oe == '0) && !dev_dqs_oe && !dqs_term)
    else $error("device drives pins while held in reset");
endmodule : ddp_link_properties

//--- tb/ddr3_data_pin_behaviour_tb.sv
// Self-checking bench joining the controller and device ends through the link interface.
module ddr3_data_pin_behaviour_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ddp_pkg::*;

  logic sys_clk = 1'b0;
  logic srst, mem_reset, req_valid, req_ready, rd_valid, lev_valid, lev_fb, mode_tdqs, mode_wlev, busy;
  ddp_req_t req_op;
  logic [2:0] req_ba;
  logic [15:0] req_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_mask;
  int fails = 0;
  int check_count = 0;
  int tdqs_cnt = 0;
  logic lev_dq0 = 1'b0;

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  ddp_if u_ddp_if ();
  ddp_ctl u_ddp_ctl (.SYS_CLK(sys_clk), .SRST(srst), .MEM_RESET(mem_reset), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_OP(req_op), .REQ_BA(req_ba), .REQ_ADDR(req_addr), .WR_DATA(wr_data),
    .WR_MASK(wr_mask), .RD_VALID(rd_valid), .RD_DATA(rd_data), .LEV_VALID(lev_valid), .LEV_FB(lev_fb),
    .LNK(u_ddp_if.ctl));
  ddp_dev u_ddp_dev (.LNK(u_ddp_if.dev), .MODE_TDQS(mode_tdqs), .MODE_WLEV(mode_wlev), .BUSY(busy));
  ddp_link_properties #(.DQ_W(DQ_W_DEF), .WL(WL_DEF), .RL(RL_DEF)) u_props (
    .ck(u_ddp_if.ck), .reset_n(u_ddp_if.reset_n), .cmd(u_ddp_if.cmd), .dq(u_ddp_if.dq),
    .dqs_t(u_ddp_if.dqs_t), .dqs_c(u_ddp_if.dqs_c), .ctl_dq_oe(u_ddp_if.ctl_dq_oe),
    .ctl_dqs_oe(u_ddp_if.ctl_dqs_oe), .ctl_dm_oe(u_ddp_if.ctl_dm_oe), .dev_dq_oe(u_ddp_if.dev_dq_oe),
    .dev_dqs_oe(u_ddp_if.dev_dqs_oe), .dqs_term(u_ddp_if.dqs_term), .tdqs_term(u_ddp_if.tdqs_term));

  // Feedback bit as seen at each link fall, where the controller captures it
  always @(negedge u_ddp_if.ck) lev_dq0 <= u_ddp_if.dq[0];
  always @(posedge sys_clk) if (u_ddp_if.tdqs_term === 1'b1) tdqs_cnt <= tdqs_cnt + 1;

  // ********
  // Shared tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic idle(input int c);
    repeat (c) @(negedge sys_clk);
  endtask : idle

  // Request held until taken; returns just after the taking edge
  task automatic issue(input ddp_req_t op, input logic [2:0] ba, input logic [15:0] ad,
                       input logic [31:0] d, input logic [3:0] m);
    int n;
    n = 0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_ba <= ba;
    req_addr <= ad;
    wr_data <= d;
    wr_mask <= m;
    do begin
      @(negedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    chk(n < 200, 1'b1);
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask : issue

  task automatic wait_answer(input bit lev, output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (((lev ? lev_valid : rd_valid) !== 1'b1) && n < 100);
  endtask : wait_answer

  task automatic mrs(input logic [2:0] ba, input logic [15:0] op);
    issue(REQ_MRS, ba, op, 32'h0, 4'h0);
    idle(12);
  endtask : mrs

  task automatic rd_check(input logic [31:0] exp);
    int n;
    issue(REQ_RD, 3'h0, 16'h0000, 32'h0, 4'h0);
    wait_answer(1'b0, n);
    chk(n, (RL_DEF + BURST_DEF + 1) * 4 + 1);
    chk(rd_data, exp);
  endtask : rd_check

  // ********
  // Scenarios
  // ********
  task automatic t_mode_select;
    mrs(3'h0, 16'h0880);
    chk({mode_tdqs, mode_wlev}, 2'h0);
    mrs(3'h1, 16'h0880);
    chk({mode_tdqs, mode_wlev}, 2'h3);
    mrs(3'h1, 16'h0000);
    chk({mode_tdqs, mode_wlev}, 2'h0);
  endtask : t_mode_select

  task automatic t_masked_write;
    issue(REQ_WR, 3'h0, 16'h0000, 32'hA3A2A1A0, 4'h0);
    issue(REQ_WR, 3'h0, 16'h0000, 32'hB7B6B5B4, 4'h5);
    idle(4);
    chk(busy, 1'b1);
    rd_check(32'hB7A2B5A0);
    chk(busy, 1'b0);
    chk(tdqs_cnt, 0);
  endtask : t_masked_write

  // In termination mode the mask is ignored, so a fully masked burst still lands
  task automatic t_tdqs_write;
    mrs(3'h1, 16'h0800);
    issue(REQ_WR, 3'h0, 16'h0000, 32'hC3C2C1C0, 4'hF);
    rd_check(32'hC3C2C1C0);
    chk(tdqs_cnt > 0, 1'b1);
  endtask : t_tdqs_write

  task automatic t_leveling;
    int n;
    mrs(3'h1, 16'h0080);
    issue(REQ_WLEV, 3'h0, 16'h0000, 32'h0, 4'h0);
    wait_answer(1'b1, n);
    chk(n, LEV_SAMPLE_C * 4 + 1);
    chk(lev_fb, lev_dq0);
    chk(lev_fb, 1'b1);
    mrs(3'h1, 16'h0800);
  endtask : t_leveling

  // Memory reset clears the mode registers but must leave the array intact
  task automatic t_mem_reset;
    chk(mode_tdqs, 1'b1);
    @(posedge sys_clk);
    mem_reset <= 1'b1;
    idle(8);
    chk(u_ddp_if.reset_n, 1'b0);
    chk(mode_tdqs, 1'b0);
    @(posedge sys_clk);
    mem_reset <= 1'b0;
    idle(8);
    chk(u_ddp_if.reset_n, 1'b1);
    rd_check(32'hC3C2C1C0);
  endtask : t_mem_reset

  initial begin
    srst = 1'b1;
    mem_reset = 1'b0;
    req_valid = 1'b0;
    req_op = REQ_MRS;
    req_ba = 3'h0;
    req_addr = 16'h0000;
    wr_data = 32'h0;
    wr_mask = 4'h0;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    idle(4);
    chk(u_ddp_if.reset_n, 1'b1);
    t_mode_select();
    t_masked_write();
    t_tdqs_write();
    t_leveling();
    t_mem_reset();
    wrap_up();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    wrap_up();
  end
endmodule : ddr3_data_pin_behaviour_tb
